// >>> logic/qwr_pkg.sv
// Purpose: Shared constants and types for the quad wiper register bank
// Assumes: 125 MHz pclk, four pots with four stored settings each
// Notes:   Host-side register offsets live here too
package qwr_pkg;

	// Clock and stored-setting write timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int NV_WRITE_MAX_MS = 10;
	localparam int NV_WRITE_CYC    = NV_WRITE_MAX_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int NV_CNT_W        = 21;

	// Array geometry
	localparam int NPOT  = 4;
	localparam int NSET  = 4;
	localparam int TAP_W = 6;
	localparam int NTAP  = 64;

	// Wiper position register fields
	localparam int                BIT_CASCADE    = 7;
	localparam int                BIT_DISCONNECT = 6;
	localparam logic [TAP_W-1:0]  TAP_MAX        = 6'h3f;
	localparam logic [TAP_W-1:0]  TAP_MIN        = 6'h00;

	// Instruction byte fields
	localparam int OP_HI  = 7;
	localparam int OP_LO  = 4;
	localparam int POT_HI = 3;
	localparam int POT_LO = 2;
	localparam int SET_HI = 1;
	localparam int SET_LO = 0;

	// Opcodes
	typedef enum logic [3:0] {
		op_rd_wiper         = 4'h9,
		op_wr_wiper         = 4'ha,
		op_rd_set           = 4'hb,
		op_wr_set           = 4'hc,
		op_set_to_wiper     = 4'hd,
		op_wiper_to_set     = 4'he,
		op_glb_set_to_wiper = 4'h1,
		op_glb_wiper_to_set = 4'h8,
		op_step             = 4'h2
	} qwr_op_t;

	// Device sequencer states
	typedef enum logic [1:0] {
		st_recall   = 2'b00,
		st_idle     = 2'b01,
		st_nv_write = 2'b10
	} qwr_dev_state_t;

	// Host register offsets and fields
	localparam logic [7:0] REG_CMD        = 8'h00;
	localparam logic [7:0] REG_STEP       = 8'h04;
	localparam logic [7:0] REG_STATUS     = 8'h08;
	localparam int         ST_REQ_PEND    = 0;
	localparam int         ST_STEP_PEND   = 1;
	localparam int         ST_LINK_READY  = 2;
	localparam int         ST_READ_DONE   = 3;
	localparam int         ST_RDATA_LO    = 8;
	localparam int         CMD_DATA_LO    = 8;

endpackage

// >>> logic/qwr_link_if.sv
// Purpose: Decoded instruction link between host and wiper register bank
// Assumes: Both ends on pclk; bus framing already stripped
// Notes:   One modport per end
`timescale 1ns/100ps
interface qwr_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic       req_valid;
	logic       req_ready;
	logic [7:0] req_instr;
	logic [7:0] req_data;
	logic       step_valid;
	logic       step_up;
	logic       rsp_valid;
	logic [7:0] rsp_data;

	// Device end
	modport dev (
		input  pclk, presetn, req_valid, req_instr, req_data, step_valid, step_up,
		output req_ready, rsp_valid, rsp_data
	);

	// Host end
	modport host (
		input  pclk, presetn, req_ready, rsp_valid, rsp_data,
		output req_valid, req_instr, req_data, step_valid, step_up
	);
endinterface

// >>> logic/qwr_device.sv
// Purpose: Four wiper position registers and sixteen stored settings
// Assumes: presetn low models power-down; release models power-up
// Notes:   Stored settings have no reset, like nonvolatile cells
//
// What this block does
// RQ1: Four 6-bit wiper registers, one-hot tap decode
// RQ2: Wiper loads by write, recall, or step
// RQ3: Power-up recalls stored setting zero into wipers
// RQ4: Wiper contents lost at power-down
// RQ5: Four stored settings per pot, both-way transfers
// RQ6: Stored-setting writes finish within 10 ms
// RQ7: Data byte: tap low six, control high two
// RQ8: Bit 7 links pot to next higher
// RQ9: Bit 6 set disconnects the wiper
// RQ10: Host keeps one wiper enabled per cascade
// RQ11: Cascaded stepping crosses into adjacent array
// RQ12: Host finds active wiper by disconnect bit
// RQ13: Host stores cascade globally before power-off
// RQ14: Cascades of three or four, 3 wraps 0
// RQ15: Instruction: opcode, pot select, setting select
// RQ16: Step high moves up, low moves down
// RQ17: Uncascaded stepping clamps at 0 and 63
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module qwr_device #(
	parameter int unsigned NV_WRITE_CYCLES = qwr_pkg::NV_WRITE_CYC
) (
	// Link to host
	qwr_link_if.dev                 lnk,
	// Analog array controls
	output logic [3:0][63:0]        tap_onehot,
	output logic [3:0]              wiper_connect,
	output logic [3:0]              cascade_link,
	output logic                    nv_busy
);
	localparam int CW = qwr_pkg::NV_CNT_W;

	qwr_pkg::qwr_dev_state_t state_reg, state_next;
	logic [3:0][7:0]         wiper_reg, wiper_next;
	logic [3:0][3:0][7:0]    store_reg, store_next;
	logic [3:0][63:0]        tap_reg, tap_next;
	logic                    inc_active_reg, inc_active_next;
	logic [1:0]              inc_pot_reg, inc_pot_next;
	logic [3:0]              nv_mask_reg, nv_mask_next;
	logic [1:0]              nv_sel_reg, nv_sel_next;
	logic [3:0][7:0]         nv_val_reg, nv_val_next;
	logic [CW-1:0]           nv_cnt_reg, nv_cnt_next;
	logic                    rsp_valid_reg, rsp_valid_next;
	logic [7:0]              rsp_data_reg, rsp_data_next;

	// Neighbour pot in a cascade ring, 3 wraps to 0
	function automatic logic [1:0] pot_step(input logic [1:0] p, input logic up);
		pot_step = up ? p + 2'h1 : p - 2'h1; // [RQ14]
	endfunction

	// Tap decode: exactly one switch closed
	function automatic logic [63:0] tap_decode(input logic [5:0] pos);
		tap_decode = 64'h1 << pos; // [RQ1]
	endfunction

	// Sequencer, instruction decode and stepping
	always_comb begin
		qwr_pkg::qwr_op_t op;
		logic [1:0]       pot;
		logic [1:0]       sel;
		logic [1:0]       np;
		logic [5:0]       pos;
		op              = qwr_pkg::qwr_op_t'(lnk.req_instr[qwr_pkg::OP_HI:qwr_pkg::OP_LO]); // [RQ15]
		pot             = lnk.req_instr[qwr_pkg::POT_HI:qwr_pkg::POT_LO];
		sel             = lnk.req_instr[qwr_pkg::SET_HI:qwr_pkg::SET_LO];
		pos             = wiper_reg[inc_pot_reg][qwr_pkg::TAP_W-1:0];
		np              = 2'h0;
		state_next      = state_reg;
		wiper_next      = wiper_reg;
		store_next      = store_reg;
		inc_active_next = inc_active_reg;
		inc_pot_next    = inc_pot_reg;
		nv_mask_next    = nv_mask_reg;
		nv_sel_next     = nv_sel_reg;
		nv_val_next     = nv_val_reg;
		nv_cnt_next     = nv_cnt_reg;
		rsp_valid_next  = 1'b0;
		rsp_data_next   = rsp_data_reg;
		case (state_reg)
			qwr_pkg::st_recall: begin
				for (int p = 0; p < qwr_pkg::NPOT; p++) begin
					wiper_next[p] = store_reg[p][0]; // [RQ3] [RQ4]
				end
				state_next = qwr_pkg::st_idle;
			end
			qwr_pkg::st_idle: begin
				if (lnk.req_valid) begin
					// Any new instruction other than op_step ends stepping mode
					inc_active_next = 1'b0;
					nv_cnt_next     = '0;
					case (op)
						qwr_pkg::op_rd_wiper: begin
							rsp_valid_next = 1'b1;
							rsp_data_next  = wiper_reg[pot];
						end
						qwr_pkg::op_wr_wiper: begin
							wiper_next[pot] = lnk.req_data; // [RQ2] [RQ7]
						end
						qwr_pkg::op_rd_set: begin
							rsp_valid_next = 1'b1;
							rsp_data_next  = store_reg[pot][sel]; // [RQ5]
						end
						qwr_pkg::op_wr_set: begin
							nv_mask_next     = 4'h1 << pot;
							nv_sel_next      = sel;
							nv_val_next[pot] = lnk.req_data; // [RQ5]
							state_next       = qwr_pkg::st_nv_write;
						end
						qwr_pkg::op_set_to_wiper: begin
							wiper_next[pot] = store_reg[pot][sel]; // [RQ2]
						end
						qwr_pkg::op_wiper_to_set: begin
							nv_mask_next     = 4'h1 << pot;
							nv_sel_next      = sel;
							nv_val_next[pot] = wiper_reg[pot]; // [RQ5]
							state_next       = qwr_pkg::st_nv_write;
						end
						qwr_pkg::op_glb_set_to_wiper: begin
							for (int p = 0; p < qwr_pkg::NPOT; p++) begin
								wiper_next[p] = store_reg[p][sel];
							end
						end
						qwr_pkg::op_glb_wiper_to_set: begin
							nv_mask_next = 4'hf;
							nv_sel_next  = sel;
							nv_val_next  = wiper_reg;
							state_next   = qwr_pkg::st_nv_write;
						end
						qwr_pkg::op_step: begin
							inc_active_next = 1'b1;
							inc_pot_next    = pot;
						end
						default: begin
							inc_active_next = 1'b0;
						end
					endcase
				end else if (lnk.step_valid && inc_active_reg) begin
					if (lnk.step_up) begin
						np = pot_step(inc_pot_reg, 1'b1);
						if (pos != qwr_pkg::TAP_MAX) begin
							wiper_next[inc_pot_reg][5:0] = pos + 6'h01; // [RQ16] [RQ2]
						end else if (wiper_reg[inc_pot_reg][qwr_pkg::BIT_CASCADE]) begin
							// Hand the wiper to the bottom of the next array
							wiper_next[inc_pot_reg][qwr_pkg::BIT_DISCONNECT] = 1'b1; // [RQ11]
							wiper_next[np][qwr_pkg::BIT_DISCONNECT]          = 1'b0;
							wiper_next[np][5:0]                               = qwr_pkg::TAP_MIN;
							inc_pot_next                                      = np; // [RQ8]
						end
						// Otherwise hold at the top tap [RQ17]
					end else begin
						np = pot_step(inc_pot_reg, 1'b0);
						if (pos != qwr_pkg::TAP_MIN) begin
							wiper_next[inc_pot_reg][5:0] = pos - 6'h01; // [RQ16]
						end else if (wiper_reg[np][qwr_pkg::BIT_CASCADE]) begin
							// Hand the wiper to the top of the lower array
							wiper_next[inc_pot_reg][qwr_pkg::BIT_DISCONNECT] = 1'b1; // [RQ11]
							wiper_next[np][qwr_pkg::BIT_DISCONNECT]          = 1'b0;
							wiper_next[np][5:0]                               = qwr_pkg::TAP_MAX;
							inc_pot_next                                      = np;
						end
						// Otherwise hold at the bottom tap [RQ17]
					end
				end
			end
			qwr_pkg::st_nv_write: begin
				// Busy for the whole write time, commit at its end
				if (nv_cnt_reg == CW'(NV_WRITE_CYCLES - 1)) begin // [RQ6]
					for (int p = 0; p < qwr_pkg::NPOT; p++) begin
						if (nv_mask_reg[p]) begin
							store_next[p][nv_sel_reg] = nv_val_reg[p];
						end
					end
					state_next = qwr_pkg::st_idle;
				end else begin
					nv_cnt_next = nv_cnt_reg + CW'(1);
				end
			end
			default: begin
				state_next = qwr_pkg::st_idle;
			end
		endcase
		for (int p = 0; p < qwr_pkg::NPOT; p++) begin
			tap_next[p] = tap_decode(wiper_next[p][5:0]);
		end
	end

	// Control state, cleared at power-down
	always_ff @(posedge lnk.pclk or negedge lnk.presetn) begin
		if (!lnk.presetn) begin
			state_reg      <= qwr_pkg::st_recall;
			wiper_reg      <= '0; // [RQ4]
			tap_reg        <= '0;
			inc_active_reg <= 1'b0;
			inc_pot_reg    <= 2'h0;
			nv_mask_reg    <= 4'h0;
			nv_sel_reg     <= 2'h0;
			nv_val_reg     <= '0;
			nv_cnt_reg     <= '0;
			rsp_valid_reg  <= 1'b0;
			rsp_data_reg   <= 8'h00;
		end else begin
			state_reg      <= state_next;
			wiper_reg      <= wiper_next;
			tap_reg        <= tap_next;
			inc_active_reg <= inc_active_next;
			inc_pot_reg    <= inc_pot_next;
			nv_mask_reg    <= nv_mask_next;
			nv_sel_reg     <= nv_sel_next;
			nv_val_reg     <= nv_val_next;
			nv_cnt_reg     <= nv_cnt_next;
			rsp_valid_reg  <= rsp_valid_next;
			rsp_data_reg   <= rsp_data_next;
		end
	end

	// Stored settings keep their value through reset
	always_ff @(posedge lnk.pclk) begin
		store_reg <= store_next;
	end

	// Outputs
	assign lnk.req_ready = (state_reg == qwr_pkg::st_idle);
	assign lnk.rsp_valid = rsp_valid_reg;
	assign lnk.rsp_data  = rsp_data_reg;
	assign tap_onehot    = tap_reg;
	assign nv_busy       = (state_reg == qwr_pkg::st_nv_write);
	always_comb begin
		for (int p = 0; p < qwr_pkg::NPOT; p++) begin
			wiper_connect[p] = ~wiper_reg[p][qwr_pkg::BIT_DISCONNECT]; // [RQ9]
			cascade_link[p]  = wiper_reg[p][qwr_pkg::BIT_CASCADE]; // [RQ8]
		end
	end

endmodule // qwr_device

// >>> logic/qwr_host.sv
// Purpose: Host end: APB registers that issue link instructions
// Assumes: Zero-wait APB slave on pclk
// Notes:   Software forms the instruction and data bytes itself
`timescale 1ns/100ps
module qwr_host (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Link to device
	qwr_link_if.host         lnk
);
	logic       req_valid_reg, req_valid_next;
	logic [7:0] instr_reg, instr_next;
	logic [7:0] data_reg, data_next;
	logic       step_valid_reg, step_valid_next;
	logic       step_up_reg, step_up_next;
	logic       rd_done_reg, rd_done_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic [31:0] prdata_reg, prdata_next;
	logic       wr_cmd, wr_step, mapped, busy_err;

	// Access decode
	always_comb begin
		mapped   = (paddr == qwr_pkg::REG_CMD) || (paddr == qwr_pkg::REG_STEP)
			|| (paddr == qwr_pkg::REG_STATUS);
		busy_err = pwrite && (paddr != qwr_pkg::REG_STATUS) && (req_valid_reg || step_valid_reg);
		wr_cmd   = psel && penable && pwrite && (paddr == qwr_pkg::REG_CMD) && !busy_err;
		wr_step  = psel && penable && pwrite && (paddr == qwr_pkg::REG_STEP) && !busy_err;
	end

	// Request, step and read-back state
	always_comb begin
		req_valid_next  = req_valid_reg;
		instr_next      = instr_reg;
		data_next       = data_reg;
		step_valid_next = step_valid_reg;
		step_up_next    = step_up_reg;
		rd_done_next    = rd_done_reg;
		rd_data_next    = rd_data_reg;
		prdata_next     = prdata_reg;
		if (lnk.req_ready) begin
			req_valid_next = 1'b0;
			if (!req_valid_reg) begin
				step_valid_next = 1'b0;
			end
		end
		if (wr_cmd) begin
			// Instruction and data bytes pass unchanged [RQ15] [RQ7] [RQ13]
			req_valid_next = 1'b1;
			instr_next     = pwdata[7:0];
			data_next      = pwdata[qwr_pkg::CMD_DATA_LO +: 8];
			rd_done_next   = 1'b0;
		end
		if (wr_step) begin
			step_valid_next = 1'b1;
			step_up_next    = pwdata[0]; // [RQ16]
		end
		if (lnk.rsp_valid) begin
			// Read-back, including disconnect bits to find the active wiper [RQ12]
			rd_done_next = 1'b1;
			rd_data_next = lnk.rsp_data;
		end
		if (psel && !penable) begin
			prdata_next = 32'h0;
			case (paddr)
				qwr_pkg::REG_CMD: begin
					prdata_next[15:0] = {data_reg, instr_reg};
				end
				qwr_pkg::REG_STEP: begin
					prdata_next[0] = step_up_reg;
				end
				qwr_pkg::REG_STATUS: begin
					prdata_next[qwr_pkg::ST_REQ_PEND]            = req_valid_reg;
					prdata_next[qwr_pkg::ST_STEP_PEND]           = step_valid_reg;
					prdata_next[qwr_pkg::ST_LINK_READY]          = lnk.req_ready;
					prdata_next[qwr_pkg::ST_READ_DONE]           = rd_done_reg;
					prdata_next[qwr_pkg::ST_RDATA_LO +: 8]       = rd_data_reg;
				end
				default: begin
					prdata_next = 32'h0;
				end
			endcase
		end
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_valid_reg  <= 1'b0;
			instr_reg      <= 8'h00;
			data_reg       <= 8'h00;
			step_valid_reg <= 1'b0;
			step_up_reg    <= 1'b0;
			rd_done_reg    <= 1'b0;
			rd_data_reg    <= 8'h00;
			prdata_reg     <= 32'h0;
		end else begin
			req_valid_reg  <= req_valid_next;
			instr_reg      <= instr_next;
			data_reg       <= data_next;
			step_valid_reg <= step_valid_next;
			step_up_reg    <= step_up_next;
			rd_done_reg    <= rd_done_next;
			rd_data_reg    <= rd_data_next;
			prdata_reg     <= prdata_next;
		end
	end

	// Outputs
	assign pready         = 1'b1;
	assign pslverr        = psel && penable && (!mapped || busy_err);
	assign prdata         = prdata_reg;
	assign lnk.req_valid  = req_valid_reg;
	assign lnk.req_instr  = instr_reg;
	assign lnk.req_data   = data_reg;
	assign lnk.step_valid = step_valid_reg;
	assign lnk.step_up    = step_up_reg;

endmodule // qwr_host

// >>> dv/qwr_link_sva.sv
// Purpose: Link checks between the host end and the device end
// Assumes: One clock domain, presetn asynchronous active low
// Notes:   Stored-write busy length is counted in helper logic
`timescale 1ns/100ps
module qwr_link_sva #(
	parameter int unsigned NV_WRITE_CYCLES = 8
) (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Requests
	input wire logic       req_valid,
	input wire logic       req_ready,
	input wire logic [7:0] req_instr,
	input wire logic [7:0] req_data,
	input wire logic       step_valid,
	input wire logic       step_up,
	// Responses
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic        take;
	logic [3:0]  op;
	logic [31:0] busy_reg;
	logic [31:0] busy_next;

	// Decode of the request taken this cycle
	assign take = req_valid && req_ready;
	assign op   = req_instr[7:4];

	// Cycles spent not ready
	always_comb begin
		busy_next = req_ready ? 32'h0 : busy_reg + 32'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 32'h0;
		end else begin
			busy_reg <= busy_next;
		end
	end

	// Request kinds
	sequence s_read_taken;
		take && (op == 4'h9 || op == 4'hb);
	endsequence
	sequence s_nv_taken;
		take && (op == 4'hc || op == 4'he || op == 4'h8);
	endsequence
	sequence s_fast_taken;
		take && (op == 4'ha || op == 4'hd || op == 4'h1 || op == 4'h2);
	endsequence

	property p_rd_answer; s_read_taken |=> rsp_valid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rsp_hold; !rsp_valid |-> $stable(rsp_data); endproperty
	a_rsp_hold: assert property (p_rsp_hold) else $error("read data moved");
	property p_nv_start; s_nv_taken |=> !req_ready; endproperty
	a_nv_start: assert property (p_nv_start) else $error("stored write not busy");
	property p_nv_full; $rose(req_ready) && busy_reg > 32'h2 |-> busy_reg == NV_WRITE_CYCLES; endproperty
	a_nv_full: assert property (p_nv_full) else $error("busy length wrong");
	property p_nv_bound; busy_reg <= NV_WRITE_CYCLES; endproperty
	a_nv_bound: assert property (p_nv_bound) else $error("busy too long");
	property p_fast_ops; s_fast_taken |=> req_ready; endproperty
	a_fast_ops: assert property (p_fast_ops) else $error("volatile op stalled");
	property p_req_hold; req_valid && !req_ready |=> req_valid && $stable({req_instr, req_data}); endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped");
	property p_step_hold; step_valid && !(req_ready && !req_valid) |=> step_valid && $stable(step_up); endproperty
	a_step_hold: assert property (p_step_hold) else $error("step dropped");
endmodule // qwr_link_sva

// >>> dv/tb.sv
// Purpose: Self-checking bench for both ends joined by the link
// Assumes: 125 MHz pclk, shortened stored-write time
// Notes:   Drives APB, watches wiper outputs
`timescale 1ns/100ps
module tb;
	localparam int unsigned NV = 8;
	logic             pclk;
	logic             presetn;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [3:0][63:0] tap_onehot;
	logic [3:0]       wiper_connect;
	logic [3:0]       cascade_link;
	logic             nv_busy;
	logic [31:0]      rd;
	logic             err;
	logic [7:0]       w [4];
	int               errors;
	int               n_checks;

	qwr_link_if lnk (.pclk(pclk), .presetn(presetn));
	qwr_host i_qwr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(lnk.host));
	qwr_device #(.NV_WRITE_CYCLES(NV)) i_qwr_device (.lnk(lnk.dev), .tap_onehot(tap_onehot),
		.wiper_connect(wiper_connect), .cascade_link(cascade_link), .nv_busy(nv_busy));
	qwr_link_sva #(.NV_WRITE_CYCLES(NV)) i_qwr_link_sva (.pclk(pclk), .presetn(presetn),
		.req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_instr(lnk.req_instr),
		.req_data(lnk.req_data), .step_valid(lnk.step_valid), .step_up(lnk.step_up),
		.rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; answer taken at the edge that completes it
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the slave; only the watchdog ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_idle();
		do begin
			apb(1'b0, qwr_pkg::REG_STATUS, 32'h0);
		end while (rd[1:0] !== 2'b00);
	endtask

	task automatic cmd(input logic [7:0] instr, input logic [7:0] data);
		apb(1'b1, qwr_pkg::REG_CMD, {16'h0, data, instr});
		chk("cmd_err", 64'h0, {63'h0, err});
		wait_idle();
	endtask

	task automatic step(input logic up);
		apb(1'b1, qwr_pkg::REG_STEP, {31'h0, up});
		chk("step_err", 64'h0, {63'h0, err});
		wait_idle();
	endtask

	task automatic rd_chk(input logic [7:0] instr, input logic [7:0] exp);
		cmd(instr, 8'h00);
		apb(1'b0, qwr_pkg::REG_STATUS, 32'h0);
		chk("read_done", 64'h1, {63'h0, rd[qwr_pkg::ST_READ_DONE]});
		chk("link_ready", 64'h1, {63'h0, rd[qwr_pkg::ST_LINK_READY]});
		chk("read_data", {56'h0, exp}, {56'h0, rd[15:8]});
	endtask

	// Wiper register read back plus its decoded outputs
	task automatic wchk(input int p);
		rd_chk({4'h9, p[1:0], 2'b00}, w[p]);
		chk("tap", 64'h1 << w[p][5:0], tap_onehot[p]);
		chk("connect", {63'h0, ~w[p][6]}, {63'h0, wiper_connect[p]});
		chk("cascade", {63'h0, w[p][7]}, {63'h0, cascade_link[p]});
	endtask

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		errors   = 0;
		n_checks = 0;
		psel     <= 1'b0;
		penable  <= 1'b0;
		pwrite   <= 1'b0;
		paddr    <= 8'h00;
		pwdata   <= 32'h0;
		do_reset();
		// Direct writes on every pot, taps from 63 down to 0
		for (int p = 0; p < 4; p++) begin
			w[p] = {p[1:0], 6'h3f - 6'(p * 21)};
			cmd({4'ha, p[1:0], 2'b00}, w[p]);
			wchk(p);
		end
		// Stored settings of pot 2, then pot 1 wiper stored to its setting 0
		for (int s = 0; s < 4; s++) cmd({4'hc, 2'd2, s[1:0]}, 8'h10 + 8'(s));
		for (int s = 0; s < 4; s++) rd_chk({4'hb, 2'd2, s[1:0]}, 8'h10 + 8'(s));
		cmd({4'hd, 2'd2, 2'd3}, 8'h00);
		w[2] = 8'h13;
		wchk(2);
		cmd({4'he, 2'd1, 2'd0}, 8'h00);
		rd_chk({4'hb, 2'd1, 2'd0}, w[1]);
		// Global store, change, global recall, then power cycle
		cmd(8'h80, 8'h00);
		cmd(8'h81, 8'h00);
		cmd(8'ha0, 8'h01);
		cmd(8'h11, 8'h00);
		for (int p = 0; p < 4; p++) wchk(p);
		cmd(8'ha4, 8'h22);
		do_reset();
		for (int p = 0; p < 4; p++) wchk(p);
		// Stepping without cascade clamps at both ends
		w[1] = 8'h3e;
		cmd(8'ha4, w[1]);
		cmd(8'h24, 8'h00);
		repeat (3) step(1'b1);
		w[1] = 8'h3f;
		wchk(1);
		cmd(8'h24, 8'h00);
		repeat (64) step(1'b0);
		w[1] = 8'h00;
		wchk(1);
		// Cascade from pot 3 wrapping into pot 0 and back
		w[3] = 8'hbf;
		w[0] = 8'h40;
		cmd(8'hac, w[3]);
		cmd(8'ha0, w[0]);
		cmd(8'h2c, 8'h00);
		repeat (2) step(1'b1);
		w[3] = 8'hff;
		w[0] = 8'h01;
		wchk(3);
		wchk(0);
		cmd(8'h20, 8'h00);
		repeat (2) step(1'b0);
		w[3] = 8'hbf;
		w[0] = 8'h40;
		wchk(3);
		wchk(0);
		// Refusals: unmapped offset, command while one is pending
		apb(1'b1, 8'h0c, 32'h1);
		chk("unmapped_wr_err", 64'h1, {63'h0, err});
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped_rd", {31'h0, 1'b1, 32'h0}, {31'h0, err, rd});
		apb(1'b1, qwr_pkg::REG_CMD, 32'h5ac4);
		apb(1'b1, qwr_pkg::REG_CMD, 32'h0094);
		apb(1'b1, qwr_pkg::REG_CMD, 32'h0094);
		chk("busy_refused", 64'h1, {63'h0, err});
		chk("nv_busy", 64'h1, {63'h0, nv_busy});
		wait_idle();
		rd_chk(8'hb4, 8'h5a);
		// Command register reads back the last instruction and data bytes
		apb(1'b0, qwr_pkg::REG_CMD, 32'h0);
		chk("cmd_readback", 64'h0000_0000_0000_00b4, {32'h0, rd});
		end_sim();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge pclk);
		errors++;
		end_sim();
	end
endmodule // tb
